// [rtl/pmr_defines.svh]
// register offsets, field positions, reset values and timing counts of the pll mode and reset control block
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH
`define PMR_OFF_GDIV      8'h60
`define PMR_OFF_GPWR      8'h64
`define PMR_OFF_GFRAC     8'h68
`define PMR_OFF_GSPREAD   8'h6c
`define PMR_OFF_GWAVE     8'h70
`define PMR_OFF_MODE      8'h80
`define PMR_OFF_MISC      8'h84
`define PMR_OFF_GLBTH     8'h8c
`define PMR_OFF_CNTTH     8'h90
`define PMR_OFF_RSTST     8'h94
`define PMR_OFF_SNDVAL    8'h98
`define PMR_OFF_FSTVAL    8'h9c
`define PMR_OFF_NDIV      8'ha0
// implemented bits of the masked 16-bit registers and of the 32-bit fraction and count threshold registers, the rest read zero except the gpwr lock bit
`define PMR_IMPL_DIV      16'hffff
`define PMR_IMPL_PWR      16'hf1ff
`define PMR_IMPL_SPREAD   16'h1fff
`define PMR_IMPL_WAVE     16'hff01
`define PMR_IMPL_MODE     16'h1113
`define PMR_IMPL_MISC     16'hbf07
`define PMR_IMPL_FRAC     32'h0fff_ffff
`define PMR_IMPL_CNTTH    32'hffff_c000
// reset values
`define PMR_RST_GDIV      16'h1051
`define PMR_RST_NDIV      16'h3064
`define PMR_RST_GPWR      16'h0042
`define PMR_RST_GFRAC     32'h00eb_84f8
`define PMR_RST_SPREAD    16'h0007
`define PMR_RST_WAVE      16'h7f00
`define PMR_RST_MODE      16'h0000
`define PMR_RST_MISC      16'ha000
`define PMR_RST_CNTTH     32'h3a98_0000
`define PMR_RST_GLBTH     32'h0000_0064
// field positions
`define PMR_BIT_BYPASS    15
`define PMR_BIT_PDSEL     15
`define PMR_BIT_PDB       14
`define PMR_BIT_PDA       13
`define PMR_BIT_DSMPD     12
`define PMR_BIT_LOCK      10
`define PMR_BIT_EXTWAVE   0
`define PMR_BIT_USBSEL    15
`define PMR_BIT_VIDSEL    13
`define PMR_BIT_WRSTWFI   2
`define PMR_BIT_SRSTWFI   1
`define PMR_BIT_WARMEN    0
`define PMR_BIT_WDTSEL    15
`define PMR_BIT_TSSEL     14
`define PMR_TEST_LAST     5'h17
`define PMR_NUM_FLAGS     6
`endif

// [rtl/pmr_pkg.sv]
// types shared by the pll mode and reset control block
package pmr_pkg;
  typedef struct packed {
    logic        bypass;
    logic [2:0]  first_post_divider;
    logic [11:0] feedback_divider;
    logic [2:0]  second_post_divider;
    logic [5:0]  reference_divider;
    logic        modulator_on;
    logic        powerdown;
    logic [3:0]  out_off;
    logic [23:0] fraction;
    logic [4:0]  spread;
    logic [3:0]  mod_freq_div;
    logic        center_spread;
    logic        mod_state_reset;
    logic        mod_module_bypass;
    logic        modulator_integration_bypass;
    logic        ext_wave_sel;
    logic [7:0]  ext_wave_maxaddr;
  } pmr_pll_ctrl_type;
  typedef struct packed {
    logic cpu_warm;
    logic cpu_soft;
    logic glb_first;
    logic glb_second;
  } pmr_rst_out_type;
endpackage

// [rtl/pmr_sync3.sv]
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pmr_sync3 #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pmr_sync3

// [rtl/pmr_lock_timer.sv]
// lock qualifier: holds the lock indicator low for the programmed oscillator cycles
`timescale 1ns/1ps
module pmr_lock_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        restart,
  input  wire logic        hold_off,
  input  wire logic        osc_tick,
  input  wire logic        analog_lock,
  input  wire logic [15:0] lock_period,
  output logic             locked_r
);
  logic [15:0] cnt_r;
  wire         cnt_done = (cnt_r >= lock_period);

  // count oscillator ticks since the last restart, saturating at the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 16'h0000;
      locked_r <= 1'b0;
    end else if (clk_en) begin
      if (restart || hold_off) begin
        cnt_r <= 16'h0000;
      end else if (osc_tick && !cnt_done) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      locked_r <= !(restart || hold_off) && cnt_done && analog_lock;
    end
  end
endmodule // pmr_lock_timer

// [rtl/pmr_ctrl.sv]
// apb register block for general pll configuration, pll modes and global reset control
`timescale 1ns/1ps
`include "pmr_defines.svh"
module pmr_ctrl (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      osc_clk_in,
  input  wire logic                      pll_lock_raw,
  input  wire logic                      cpu_wfi,
  input  wire logic                      watchdog_reset_request,
  input  wire logic                      thermal_reset_request,
  input  wire logic                      warm_reset_request,
  input  wire logic                      cpu_soft_reset_request,
  output pmr_pkg::pmr_pll_ctrl_type      gpll_ctrl,
  output logic      [14:0]               fifth_pll_div,
  output logic      [4:0]                pll_normal_mode,
  output logic                           usb_phy_clock_force_low,
  output logic                           video_phy_clock_force_low,
  output logic      [4:0]                test_clock_index,
  output logic                           test_clock_wireless,
  output pmr_pkg::pmr_rst_out_type       rst_out,
  output logic      [15:0]               first_reset_value,
  output logic      [15:0]               second_reset_value
);
  import pmr_pkg::*;

  // masked write: upper half enables the matching lower data bit
  function automatic logic [15:0] mask_wr(input logic [15:0] old, input logic [31:0] d);
    mask_wr = (old & ~d[31:16]) | (d[15:0] & d[31:16]);
  endfunction

  logic [15:0] gdiv_r, ndiv_r, gpwr_r, spread_r, wave_r, mode_r, misc_r;
  logic [15:0] sndval_r, fstval_r;
  logic [31:0] gfrac_r, cntth_r, glbth_r, glb_cnt_r;
  logic [5:0]  flags_r;
  logic        chg_r, pwr_prev_r, osc_prev_r, wdt_prev_r, ts_prev_r;
  logic [4:0]  pin_s;
  logic        lock_q;

  // apb: one wait state; the answer lands on the edge that raises pready, the write on the edge after it
  wire access = psel && penable;
  wire commit = access && pready;
  wire wr     = commit && pwrite;

  wire hit_gdiv   = (paddr == `PMR_OFF_GDIV);
  wire hit_gpwr   = (paddr == `PMR_OFF_GPWR);
  wire hit_gfrac  = (paddr == `PMR_OFF_GFRAC);
  wire hit_spread = (paddr == `PMR_OFF_GSPREAD);
  wire hit_wave   = (paddr == `PMR_OFF_GWAVE);
  wire hit_mode   = (paddr == `PMR_OFF_MODE);
  wire hit_misc   = (paddr == `PMR_OFF_MISC);
  wire hit_glbth  = (paddr == `PMR_OFF_GLBTH);
  wire hit_cntth  = (paddr == `PMR_OFF_CNTTH);
  wire hit_rstst  = (paddr == `PMR_OFF_RSTST);
  wire hit_sndval = (paddr == `PMR_OFF_SNDVAL);
  wire hit_fstval = (paddr == `PMR_OFF_FSTVAL);
  wire hit_ndiv   = (paddr == `PMR_OFF_NDIV);
  wire hit_any    = hit_gdiv | hit_gpwr | hit_gfrac | hit_spread | hit_wave | hit_mode | hit_misc |
                    hit_glbth | hit_cntth | hit_rstst | hit_sndval | hit_fstval | hit_ndiv;

  // next values of the masked registers and of the fraction register
  wire [15:0] gdiv_nxt   = mask_wr(gdiv_r, pwdata) & `PMR_IMPL_DIV;
  wire [15:0] ndiv_nxt   = mask_wr(ndiv_r, pwdata) & `PMR_IMPL_DIV;
  wire [15:0] gpwr_nxt   = mask_wr(gpwr_r, pwdata) & `PMR_IMPL_PWR & ~(16'h0001 << `PMR_BIT_LOCK);
  wire [15:0] spread_nxt = mask_wr(spread_r, pwdata) & `PMR_IMPL_SPREAD;
  wire [15:0] wave_nxt   = mask_wr(wave_r, pwdata) & `PMR_IMPL_WAVE;
  wire [15:0] mode_nxt   = mask_wr(mode_r, pwdata) & `PMR_IMPL_MODE;
  wire [15:0] misc_nxt   = mask_wr(misc_r, pwdata) & `PMR_IMPL_MISC;
  wire [31:0] gfrac_nxt  = pwdata & `PMR_IMPL_FRAC;

  // a change of any reference, feedback or fraction divider restarts lock qualification and, with the select bit clear, pulses power-down
  wire div_change = wr && ((hit_gdiv && gdiv_nxt[11:0] != gdiv_r[11:0]) ||
                           (hit_gpwr && gpwr_nxt[5:0] != gpwr_r[5:0]) ||
                           (hit_gfrac && gfrac_nxt[23:0] != gfrac_r[23:0]));

  // power-down source: request b alone, or request a plus divider changes
  wire pd_now = gpwr_r[`PMR_BIT_PDSEL] ? gpwr_r[`PMR_BIT_PDB] :
                (gpwr_r[`PMR_BIT_PDA] || chg_r);

  // oscillator ticks come from the settled, synchronised level
  wire osc_tick = pin_s[0] && !osc_prev_r;
  wire wfi_s    = pin_s[2];
  wire wdt_ev   = pin_s[3] && !wdt_prev_r;
  wire ts_ev    = pin_s[4] && !ts_prev_r;

  // global reset events and their routing
  wire sw_first   = wr && hit_fstval;
  wire sw_second  = wr && hit_sndval;
  wire wdt_first  = wdt_ev && cntth_r[`PMR_BIT_WDTSEL];
  wire wdt_second = wdt_ev && !cntth_r[`PMR_BIT_WDTSEL];
  wire ts_first   = ts_ev && cntth_r[`PMR_BIT_TSSEL];
  wire ts_second  = ts_ev && !cntth_r[`PMR_BIT_TSSEL];
  wire glb_first  = sw_first || wdt_first || ts_first;
  wire glb_second = sw_second || wdt_second || ts_second;
  wire [5:0] flag_set = {ts_second, ts_first, wdt_second, wdt_first, sw_second, sw_first};
  wire [5:0] flag_clr = (wr && hit_rstst) ? pwdata[5:0] : 6'h00;

  // cpu reset qualification
  wire warm_go = misc_r[`PMR_BIT_WARMEN] && warm_reset_request &&
                 (!misc_r[`PMR_BIT_WRSTWFI] || wfi_s);
  wire soft_go = misc_r[`PMR_BIT_SRSTWFI] ? (wfi_s && cpu_soft_reset_request) :
                 cpu_soft_reset_request;

  // read mux; write-only registers read as zero
  wire [31:0] rd_mux =
    hit_gdiv  ? {16'h0000, gdiv_r} :
    hit_gpwr  ? {16'h0000, gpwr_r | (16'(lock_q) << `PMR_BIT_LOCK)} :
    hit_gfrac ? gfrac_r :
    hit_mode  ? {16'h0000, mode_r} :
    hit_misc  ? {16'h0000, misc_r} :
    hit_glbth ? glbth_r :
    hit_cntth ? cntth_r :
    hit_rstst ? {26'h000_0000, flags_r} :
    hit_sndval ? {16'h0000, sndval_r} :
    hit_fstval ? {16'h0000, fstval_r} :
    hit_ndiv  ? {16'h0000, ndiv_r} : 32'h0000_0000;

  // pin inputs from other domains
  pmr_sync3 #(.W(5)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({thermal_reset_request, watchdog_reset_request, cpu_wfi, pll_lock_raw, osc_clk_in}),
    .sync_out (pin_s)
  );

  // lock qualification restarts on power-up or divider change
  pmr_lock_timer u_lock (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .restart     (div_change || (pwr_prev_r && !pd_now)),
    .hold_off    (pd_now),
    .osc_tick    (osc_tick),
    .analog_lock (pin_s[1]),
    .lock_period (cntth_r[31:16]),
    .locked_r    (lock_q)
  );

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= access && !pready && !hit_any;
    end
  end

  // register file; writes to unmapped addresses are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gdiv_r   <= `PMR_RST_GDIV;
      ndiv_r   <= `PMR_RST_NDIV;
      gpwr_r   <= `PMR_RST_GPWR;
      gfrac_r  <= `PMR_RST_GFRAC;
      spread_r <= `PMR_RST_SPREAD;
      wave_r   <= `PMR_RST_WAVE;
      mode_r   <= `PMR_RST_MODE;
      misc_r   <= `PMR_RST_MISC;
      cntth_r  <= `PMR_RST_CNTTH;
      glbth_r  <= `PMR_RST_GLBTH;
      sndval_r <= 16'h0000;
      fstval_r <= 16'h0000;
    end else if (clk_en && wr) begin
      if (hit_gdiv)   gdiv_r   <= gdiv_nxt;
      if (hit_ndiv)   ndiv_r   <= ndiv_nxt;
      if (hit_gpwr)   gpwr_r   <= gpwr_nxt;
      if (hit_gfrac)  gfrac_r  <= gfrac_nxt;
      if (hit_spread) spread_r <= spread_nxt;
      if (hit_wave)   wave_r   <= wave_nxt;
      if (hit_mode)   mode_r   <= mode_nxt;
      if (hit_misc)   misc_r   <= misc_nxt;
      if (hit_cntth)  cntth_r  <= pwdata & `PMR_IMPL_CNTTH;
      if (hit_glbth)  glbth_r  <= pwdata;
      if (hit_sndval) sndval_r <= pwdata[15:0];
      if (hit_fstval) fstval_r <= pwdata[15:0];
    end
  end

  // sticky cause flags: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 6'h00;
    end else if (clk_en) begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // edge history for pins, power state and the one-cycle divider change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_r      <= 1'b0;
      pwr_prev_r <= 1'b1;
      osc_prev_r <= 1'b0;
      wdt_prev_r <= 1'b0;
      ts_prev_r  <= 1'b0;
    end else if (clk_en) begin
      chg_r      <= div_change && !gpwr_r[`PMR_BIT_PDSEL];
      pwr_prev_r <= pd_now;
      osc_prev_r <= pin_s[0];
      wdt_prev_r <= pin_s[3];
      ts_prev_r  <= pin_s[4];
    end
  end

  // global reset pulse lasts the threshold count from the latest event, which reloads the count and replaces a running pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_cnt_r <= 32'h0000_0000;
      rst_out   <= '0;
    end else if (clk_en) begin
      if (glb_first || glb_second) begin
        glb_cnt_r          <= glbth_r;
        rst_out.glb_first  <= glb_first;
        rst_out.glb_second <= glb_second && !glb_first;
      end else if (glb_cnt_r > 32'h0000_0001) begin
        glb_cnt_r <= glb_cnt_r - 32'h0000_0001;
      end else begin
        glb_cnt_r          <= 32'h0000_0000;
        rst_out.glb_first  <= 1'b0;
        rst_out.glb_second <= 1'b0;
      end
      rst_out.cpu_warm <= warm_go;
      rst_out.cpu_soft <= soft_go;
    end
  end

  // pll control outputs follow the registers one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpll_ctrl <= '0;
      fifth_pll_div <= 15'h0000;
      pll_normal_mode <= 5'h00;
      usb_phy_clock_force_low <= 1'b1;
      video_phy_clock_force_low <= 1'b1;
      test_clock_index <= 5'h00;
      test_clock_wireless <= 1'b0;
      first_reset_value <= 16'h0000;
      second_reset_value <= 16'h0000;
    end else if (clk_en) begin
      gpll_ctrl.bypass <= gdiv_r[`PMR_BIT_BYPASS];
      gpll_ctrl.first_post_divider <= gdiv_r[14:12];
      gpll_ctrl.feedback_divider <= gdiv_r[11:0];
      gpll_ctrl.second_post_divider <= gpwr_r[8:6];
      gpll_ctrl.reference_divider <= gpwr_r[5:0];
      gpll_ctrl.modulator_on <= !gpwr_r[`PMR_BIT_DSMPD];
      gpll_ctrl.powerdown <= pd_now;
      gpll_ctrl.out_off <= gfrac_r[27:24];
      gpll_ctrl.fraction <= gfrac_r[23:0];
      gpll_ctrl.spread <= spread_r[12:8];
      gpll_ctrl.mod_freq_div <= spread_r[7:4];
      gpll_ctrl.center_spread <= spread_r[3];
      gpll_ctrl.mod_state_reset <= spread_r[2];
      gpll_ctrl.mod_module_bypass <= spread_r[1];
      gpll_ctrl.modulator_integration_bypass <= spread_r[0];
      gpll_ctrl.ext_wave_sel <= wave_r[`PMR_BIT_EXTWAVE];
      gpll_ctrl.ext_wave_maxaddr <= wave_r[15:8];
      fifth_pll_div <= ndiv_r[14:0];
      pll_normal_mode <= {mode_r[12], mode_r[8], mode_r[4], mode_r[1], mode_r[0]};
      usb_phy_clock_force_low <= misc_r[`PMR_BIT_USBSEL];
      video_phy_clock_force_low <= misc_r[`PMR_BIT_VIDSEL];
      test_clock_index <= misc_r[12:8];
      test_clock_wireless <= (misc_r[12:8] > `PMR_TEST_LAST);
      first_reset_value <= fstval_r;
      second_reset_value <= sndval_r;
    end
  end

  // checks
  property p_mask_keep;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (wr && hit_mode && !pwdata[16]) |=> (mode_r[0] == $past(mode_r[0]));
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");
  property p_bypass;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (wr && hit_gdiv && pwdata[31]) |=> ##1 (gpll_ctrl.bypass == $past(pwdata[15], 2));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not routed");
  property p_pdsel;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (gpwr_r[15] && !gpwr_r[14]) |=> !gpll_ctrl.powerdown;
  endproperty
  a_pdsel: assert property (p_pdsel) else $error("powerdown not gated by select");
  property p_dsm;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    $rose(gpwr_r[12]) |=> !gpll_ctrl.modulator_on;
  endproperty
  a_dsm: assert property (p_dsm) else $error("modulator enable inverted");
  property p_lock_ro;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (access && !pready && !pwrite && hit_gpwr) |=> (prdata[10] == $past(lock_q));
  endproperty
  a_lock_ro: assert property (p_lock_ro) else $error("lock bit misread");
  property p_test_sel;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (misc_r[12:8] == 5'h18) |=> test_clock_wireless;
  endproperty
  a_test_sel: assert property (p_test_sel) else $error("fallback clock not chosen");
  property p_warm;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    !misc_r[0] |=> !rst_out.cpu_warm;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset without enable");
  property p_soft;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (misc_r[1] && !wfi_s) |=> !rst_out.cpu_soft;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset without wfi");
  property p_route;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (wdt_ev && !ts_ev && !sw_first && !sw_second && !cntth_r[15]) |=> (rst_out.glb_second && !rst_out.glb_first);
  endproperty
  a_route: assert property (p_route) else $error("watchdog misrouted");
  property p_flag_set;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    flag_set[3] |=> flags_r[3];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("cause flag lost");
  property p_lock_wait;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    div_change |=> !lock_q [*2];
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock shown too early");
  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr && hit_gdiv);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
  c_glb: cover property (@(posedge pclk) disable iff (!presetn) $rose(rst_out.glb_first));
endmodule // pmr_ctrl

// [dv/tb_top.sv]
// self-checking apb testbench of the pll mode and reset control block
`timescale 1ns/1ps
module tb_top;
  import pmr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        osc_clk_in = 0, pll_lock_raw = 0, cpu_wfi = 0, wdt_req = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd;
  logic        pready, pslverr;
  logic        ts_req = 0, warm_req = 0, soft_req = 0, usb_sel, vid_sel, tc_wifi;
  logic [14:0] ndiv_out;
  logic [4:0]  tc_idx;
  logic [15:0] fst_val;
  pmr_pll_ctrl_type pll;
  pmr_rst_out_type  rst;
  logic [15:0] snd_val;
  logic [4:0]  mode;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [7:0]  ra[10] = '{8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h80, 8'h84, 8'h90, 8'h8c, 8'h94};
  logic [31:0] rv[10] = '{32'h0000_1051, 32'h0000_0042, 32'h00eb_84f8, 32'h0, 32'h0, 32'h0, 32'h0000_a000,
                          32'h3a98_0000, 32'h0000_0064, 32'h0};
  int          failures = 0, samples_checked = 0, cyc = 0;

  // 200 MHz register clock and a slower oscillator made from it
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (cyc % 3 == 0) osc_clk_in <= ~osc_clk_in;

  pmr_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_clk_in(osc_clk_in),
    .pll_lock_raw(pll_lock_raw), .cpu_wfi(cpu_wfi), .watchdog_reset_request(wdt_req),
    .thermal_reset_request(ts_req), .warm_reset_request(warm_req), .cpu_soft_reset_request(soft_req),
    .gpll_ctrl(pll), .fifth_pll_div(ndiv_out), .pll_normal_mode(mode), .usb_phy_clock_force_low(usb_sel),
    .video_phy_clock_force_low(vid_sel), .test_clock_index(tc_idx), .test_clock_wireless(tc_wifi),
    .rst_out(rst), .first_reset_value(fst_val), .second_reset_value(snd_val));

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // the monitor takes the oldest note whenever the slave answers
  always @(posedge pclk) if (pready === 1'b1) begin
    e = q.pop_front();
    chk({pslverr, prdata} === e, "apb response mismatch");
  end

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; q.push_back(x);
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic results();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  initial begin
    rnd = $urandom(32'h0000_99f2);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'ha0, 32'h0000_3064);
    chk(ndiv_out === 15'h3064 && usb_sel === 1'b1 && vid_sel === 1'b1, "reset outputs");
    chk(pll.modulator_on === 1'b1 && pll.mod_state_reset === 1'b1, "modulator reset");
    chk(pll.mod_module_bypass === 1'b1 && pll.modulator_integration_bypass === 1'b1, "bypass reset");
    chk(pll.ext_wave_maxaddr === 8'h7f && pll.ext_wave_sel === 1'b0, "wave reset");
    apb(1'b0, 8'hfc, 32'h0, {1'b1, 32'h0});
    // bypass with dividers kept inside their legal ranges
    wr(8'h60, 32'hffff_a0c8);
    rd(8'h60, 32'h0000_a0c8);
    chk(pll.bypass === 1'b1 && pll.feedback_divider === 12'h0c8, "bypass route");
    chk(pll.first_post_divider === 3'h2, "post divider");
    wr(8'h80, 32'h1000_ffff);
    rd(8'h80, 32'h0000_1000);
    chk(mode === 5'h10, "mode output");
    wr(8'h64, 32'h0400_0400);
    rd(8'h64, 32'h0000_0042);
    // select bit hands power-down to request b alone
    wr(8'h64, 32'hd000_9000);
    rd(8'h64, 32'h0000_9042);
    chk(pll.powerdown === 1'b0 && pll.modulator_on === 1'b0, "dsm off, powered");
    chk(pll.second_post_divider === 3'h1 && pll.reference_divider === 6'h02, "pwr dividers");
    wr(8'h64, 32'h2000_2000);
    rd(8'h64, 32'h0000_b042);
    chk(pll.powerdown === 1'b0, "request a ignored");
    wr(8'h64, 32'hd000_0000);
    rd(8'h64, 32'h0000_2042);
    chk(pll.powerdown === 1'b1 && pll.modulator_on === 1'b1, "request a powers down");
    wr(8'h64, 32'h2000_0000);
    // spread and wave registers are write-only, so they are seen on the outputs
    wr(8'h6c, 32'hffff_15ab);
    wr(8'h70, 32'hffff_4001);
    rd(8'h70, 32'h0);
    chk(pll.spread === 5'h15 && pll.mod_freq_div === 4'ha, "spread cfg");
    chk(pll.center_spread === 1'b1, "center spread");
    chk(pll.mod_state_reset === 1'b0 && pll.mod_module_bypass === 1'b1, "modulator ctl");
    chk(pll.ext_wave_sel === 1'b1 && pll.ext_wave_maxaddr === 8'h40, "wave cfg");
    // wfi-qualified cpu resets and the fallback test clock
    wr(8'h84, 32'hff07_1807);
    rd(8'h84, 32'h0000_1807);
    chk(usb_sel === 1'b0 && vid_sel === 1'b0, "phy clock select");
    chk(tc_idx === 5'h18 && tc_wifi === 1'b1, "fallback test clock");
    warm_req <= 1;
    soft_req <= 1;
    repeat (6) @(posedge pclk);
    chk(rst.cpu_warm === 1'b0 && rst.cpu_soft === 1'b0, "cpu reset before wfi");
    cpu_wfi <= 1;
    repeat (6) @(posedge pclk);
    chk(rst.cpu_warm === 1'b1 && rst.cpu_soft === 1'b1, "cpu reset on wfi");
    cpu_wfi <= 0;
    wr(8'h84, 32'h1f07_1700);
    rd(8'h84, 32'h0000_1700);
    chk(rst.cpu_warm === 1'b0 && rst.cpu_soft === 1'b1, "unqualified soft reset");
    chk(tc_idx === 5'h17 && tc_wifi === 1'b0, "last internal test clock");
    warm_req <= 0;
    soft_req <= 0;
    rnd = $urandom;
    wr(8'h68, rnd);
    rd(8'h68, rnd & 32'h0fff_ffff);
    chk(pll.out_off === rnd[27:24] && pll.fraction === rnd[23:0], "fraction outputs");
    rnd = $urandom;
    wr(8'h98, rnd);
    wr(8'h9c, ~rnd);
    rd(8'h98, {16'h0, rnd[15:0]});
    chk(snd_val === rnd[15:0] && fst_val === ~rnd[15:0], "value copy");
    rd(8'h94, 32'h0000_0003);
    wr(8'h94, 32'h0000_0003);
    rd(8'h94, 32'h0);
    // default routing sends watchdog and thermal events to the second global reset
    wdt_req <= 1;
    repeat (8) @(posedge pclk);
    chk(rst.glb_second === 1'b1 && rst.glb_first === 1'b0, "watchdog to second");
    wdt_req <= 0;
    ts_req <= 1;
    repeat (8) @(posedge pclk);
    ts_req <= 0;
    rd(8'h94, 32'h0000_0028);
    wr(8'h94, 32'h0000_0028);
    // short lock period, watchdog routed to the first global reset
    wr(8'h90, 32'h0004_8000);
    pll_lock_raw <= 1;
    wdt_req <= 1;
    repeat (8) @(posedge pclk);
    chk(rst.glb_first === 1'b1 && rst.glb_second === 1'b0, "watchdog to first");
    wdt_req <= 0;
    repeat (40) @(posedge pclk);
    rd(8'h94, 32'h0000_0004);
    rd(8'h64, 32'h0000_0442);
    rd(8'h90, 32'h0004_8000);
    results();
  end
endmodule // tb_top
